// [design/uwcr_pkg.sv]
package uwcr_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses on the plain register port)
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_FRAMING_EN  = 8'h04;
   localparam logic [7:0]  OFS_RX_AUTO_REQUEST_MODES     = 8'h08;
   localparam logic [7:0]  OFS_SRC_RAW     = 8'h0c;
   localparam logic [7:0]  OFS_SRC_SET     = 8'h10;
   localparam logic [7:0]  OFS_SRC_CLR     = 8'h14;
   localparam logic [7:0]  OFS_SRC_MASK    = 8'h18;
   localparam logic [7:0]  OFS_SRC_MASKED  = 8'h1c;
   localparam logic [7:0]  OFS_CONTROL     = 8'h20;
   // ------------------------------------------------------------
   // Field layouts and reset values
   // ------------------------------------------------------------
   localparam int          STAT_VBUS_BIT   = 0;
   localparam logic [31:0] FRAMING_MASK    = 32'h000f_000f;
   localparam int          FRAMING_TX_LSB  = 0;
   localparam int          FRAMING_RX_LSB  = 16;
   localparam logic [31:0] RX_AUTO_REQUEST_MODES_MASK    = 32'h0000_00ff;
   localparam logic [31:0] SRC_MASK        = 32'h01ff_1e1f;
   localparam int          CTRL_GLOBAL_BIT = 4;
   localparam logic [31:0] CTRL_MASK       = 32'h0000_0010;
   localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;
   localparam int          NUM_EP          = 4;
   // Automatic-request mode codes
   typedef enum logic [1:0] {
      UWCR_AR_NONE     = 2'b00,
      UWCR_AR_ALL_BUT  = 2'b01,
      UWCR_AR_RESERVED = 2'b10,
      UWCR_AR_ALWAYS   = 2'b11
   } uwcr_rx_auto_request_modes_t;
endpackage : uwcr_pkg

// [design/uwcr_regs.sv]
// How it works
// R01: Status bit 0 reads the present VBUS-drive output level.
// R02: Receive endpoint 1-4 framing enables sit in bits 16-19.
// R03: Transmit endpoint 1-4 framing enables sit in bits 0-3.
// R04: Two-bit auto-request field per receive endpoint, bits 1-0 up to 7-6.
// R05: Codes 0 none, 1 all but last, 3 always; 2 reserved.
// R06: Raw sources: core 24-16, receive 12-9, transmit 4-0, reset zero.
// R07: Writing one to the set register sets that source bit.
// R08: Writing one to the clear register clears that source bit.
// R09: Zero bits written change nothing; reserved bits read zero.
// R10: Hardware event beats a same-cycle software clear.
// R11: A mask bit per source gates it into the masked view.
// R12: Global framing enable in control applies to all endpoints.
module uwcr_regs
   import uwcr_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   // Register port
   input  wire logic [uwcr_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [31:0]              reg_rdata,
   // Core side
   input  wire logic                     vbus_drive_level,
   input  wire logic [31:0]              core_events,
   // Steering outputs
   output logic      [3:0]               tx_framing_active,
   output logic      [3:0]               rx_framing_active,
   output logic      [7:0]               rx_auto_request_modes,
   // Interrupt
   output logic                          irq
);
   import uwcr_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [31:0] framing_q, framing_d;
   logic [31:0] rx_auto_request_modes_q, rx_auto_request_modes_d;
   logic [31:0] mask_q, mask_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic        wr_set, wr_clr;
   logic [31:0] src_q;

   // Writes keep only implemented bits
   always_comb begin
      framing_d = framing_q;
      rx_auto_request_modes_d = rx_auto_request_modes_q;
      mask_d    = mask_q;
      ctrl_d    = ctrl_q;
      if (reg_write) begin
         unique case (reg_addr)
            OFS_FRAMING_EN: framing_d = reg_wdata & FRAMING_MASK; // see R02 see R03 see R09
            OFS_RX_AUTO_REQUEST_MODES:    rx_auto_request_modes_d = reg_wdata & RX_AUTO_REQUEST_MODES_MASK; // see R04 see R09
            OFS_SRC_MASK:   mask_d    = reg_wdata & SRC_MASK;     // see R11
            OFS_CONTROL:    ctrl_d    = reg_wdata & CTRL_MASK;    // see R12
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         framing_q <= RESET_ZERO;
         rx_auto_request_modes_q <= RESET_ZERO;
         mask_q    <= RESET_ZERO;
         ctrl_q    <= RESET_ZERO;
      end else begin
         framing_q <= framing_d;
         rx_auto_request_modes_q <= rx_auto_request_modes_d;
         mask_q    <= mask_d;
         ctrl_q    <= ctrl_d;
      end
   end

   // ------------------------------------------------------------
   // Raw interrupt sources
   // ------------------------------------------------------------
   assign wr_set = reg_write && (reg_addr == OFS_SRC_SET);
   assign wr_clr = reg_write && (reg_addr == OFS_SRC_CLR);

   uwcr_src_bits #(
      .WIDTH (32)
   ) u_src (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .hw_set     (core_events),                            // see R06
      .sw_set     (wr_set ? reg_wdata : RESET_ZERO),        // see R07
      .sw_clr     (wr_clr ? reg_wdata : RESET_ZERO),        // see R08
      .valid_bits (SRC_MASK),
      .bits_q     (src_q)
   );

   // ------------------------------------------------------------
   // Outputs and read path
   // ------------------------------------------------------------
   logic [31:0] rdata_d;
   logic [3:0]  tx_act_d, rx_act_d;
   logic [7:0]  ar_d;
   logic        irq_d;

   // Reserved code 2 is passed through; software must avoid it
   always_comb begin
      tx_act_d = framing_q[FRAMING_TX_LSB +: NUM_EP]
                 | {NUM_EP{ctrl_q[CTRL_GLOBAL_BIT]}};       // see R03 see R12
      rx_act_d = framing_q[FRAMING_RX_LSB +: NUM_EP]
                 | {NUM_EP{ctrl_q[CTRL_GLOBAL_BIT]}};       // see R02 see R12
      ar_d     = rx_auto_request_modes_q[7:0];                             // see R05
      irq_d    = |(src_d_view() & mask_q);                   // see R11
      rdata_d  = RESET_ZERO;
      if (reg_read) begin
         unique case (reg_addr)
            OFS_STATUS:     rdata_d[STAT_VBUS_BIT] = vbus_drive_level; // see R01
            OFS_FRAMING_EN: rdata_d = framing_q;
            OFS_RX_AUTO_REQUEST_MODES:    rdata_d = rx_auto_request_modes_q;
            OFS_SRC_RAW:    rdata_d = src_q;                 // see R06
            OFS_SRC_MASK:   rdata_d = mask_q;
            OFS_SRC_MASKED: rdata_d = src_q & mask_q;        // see R11
            OFS_CONTROL:    rdata_d = ctrl_q;
            default:        rdata_d = RESET_ZERO;            // see R09
         endcase
      end
   end

   // Interrupt follows registered sources one cycle later
   function automatic logic [31:0] src_d_view();
      src_d_view = src_q;
   endfunction : src_d_view

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata             <= RESET_ZERO;
         tx_framing_active     <= 4'h0;
         rx_framing_active     <= 4'h0;
         rx_auto_request_modes <= 8'h00;
         irq                   <= 1'b0;
      end else begin
         reg_rdata             <= rdata_d;
         tx_framing_active     <= tx_act_d;
         rx_framing_active     <= rx_act_d;
         rx_auto_request_modes <= ar_d;
         irq                   <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_set_wins_clear: assert property (@(posedge clk_sys) disable iff (reset)
      (core_events[0] && wr_clr && reg_wdata[0]) |=> src_q[0]) // see R10
      else $error("hardware set lost to clear");
   a_sw_set_bit: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_set && reg_wdata[16]) |=> src_q[16]) // see R07
      else $error("set register did not set source");
   a_sw_clr_bit: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_clr && reg_wdata[9] && !core_events[9] && !wr_set) |=> !src_q[9]) // see R08
      else $error("clear register did not clear source");
   a_src_reserved: assert property (@(posedge clk_sys) disable iff (reset)
      (src_q & ~SRC_MASK) == 32'h0000_0000) // see R06 see R09
      else $error("reserved source bit set");
   a_status_vbus: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_read && reg_addr == OFS_STATUS) |=> reg_rdata == {31'h0, $past(vbus_drive_level)}) // see R01
      else $error("status does not mirror vbus drive");
   a_rx_framing: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_write && reg_addr == OFS_FRAMING_EN) |=> ##1
      rx_framing_active[0] == ($past(reg_wdata[16], 2) | $past(ctrl_q[CTRL_GLOBAL_BIT]))) // see R02
      else $error("rx endpoint 1 framing wrong");
   a_tx_framing: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_write && reg_addr == OFS_FRAMING_EN) |=> ##1
      tx_framing_active[3] == ($past(reg_wdata[3], 2) | $past(ctrl_q[CTRL_GLOBAL_BIT]))) // see R03
      else $error("tx endpoint 4 framing wrong");
   a_rx_auto_request_modes_ep4: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_write && reg_addr == OFS_RX_AUTO_REQUEST_MODES) |=> ##1
      rx_auto_request_modes[7:6] == $past(reg_wdata[7:6], 2)) // see R04
      else $error("endpoint 4 auto request field wrong");
   a_irq_masked: assert property (@(posedge clk_sys) disable iff (reset)
      irq == $past(|(src_q & mask_q))) // see R11
      else $error("interrupt does not follow masked sources");
   a_global_mode: assert property (@(posedge clk_sys) disable iff (reset)
      ctrl_q[CTRL_GLOBAL_BIT] |=> (&tx_framing_active && &rx_framing_active)) // see R12
      else $error("global framing enable not applied");
   // Read data must not linger, or software could pick up a stale word
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
      !reg_read |=> reg_rdata == 32'h0000_0000) // see R09
      else $error("read data stands outside its cycle");
   a_masked_view: assert property (@(posedge clk_sys) disable iff (reset)
      (reg_read && reg_addr == OFS_SRC_MASKED) |=> reg_rdata == $past(src_q & mask_q)) // see R11
      else $error("masked view wrong");
endmodule : uwcr_regs

// [design/uwcr_src_bits.sv]
module uwcr_src_bits
   import uwcr_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // Set and clear terms
   input  wire logic [WIDTH-1:0] hw_set,
   input  wire logic [WIDTH-1:0] sw_set,
   input  wire logic [WIDTH-1:0] sw_clr,
   input  wire logic [WIDTH-1:0] valid_bits,
   // State
   output logic      [WIDTH-1:0] bits_q
);
   logic [WIDTH-1:0] bits_d;

   // Set wins over clear so a same-cycle event survives
   always_comb begin
      bits_d = ((bits_q & ~sw_clr) | hw_set | sw_set) & valid_bits; // see R10 see R09
   end

   // Register stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bits_q <= '0;
      end else begin
         bits_q <= bits_d;
      end
   end
endmodule : uwcr_src_bits

// [test/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uwcr_pkg::*;
   // ------------------------------------------------------------
   // Signals and bookkeeping
   // ------------------------------------------------------------
   logic              clk_sys          = 1'b0;
   logic              reset            = 1'b1;
   logic [ADDR_W-1:0] reg_addr         = 8'h00;
   logic [31:0]       reg_wdata        = 32'h0;
   logic              reg_write        = 1'b0;
   logic              reg_read         = 1'b0;
   logic [31:0]       reg_rdata;
   logic              vbus_drive_level = 1'b0;
   logic [31:0]       core_events      = 32'h0;
   logic [3:0]        tx_act, rx_act;
   logic [7:0]        ar_modes;
   logic              irq;
   logic              pend             = 1'b0;
   logic [31:0]       b, w, c, exp_q[$];
   logic [1:0]        cd;
   int                n_fail           = 0;
   int                checks           = 0;
   int                seed             = 32'h3ad0;
   // Clock at 25 MHz
   always #20 clk_sys = ~clk_sys;
   uwcr_regs uwcr_regs_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .vbus_drive_level(vbus_drive_level),
      .core_events(core_events), .tx_framing_active(tx_act), .rx_framing_active(rx_act),
      .rx_auto_request_modes(ar_modes), .irq(irq));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   // Expected read value is queued for the watcher
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      exp_q.push_back(exp);
      @(posedge clk_sys);
      reg_read <= 1'b0;
   endtask : rd
   // Levels lag the register by one cycle, so wait two
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle
   task automatic report_and_stop();
      if (exp_q.size() != 0) n_fail++;
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // Watcher: read data stands only in the cycle after the strobe
   always @(posedge clk_sys) pend <= reg_read;
   always @(negedge clk_sys) begin
      if (pend && exp_q.size() == 0) chk(reg_rdata, 32'hdead_0000);
      else if (pend) chk(reg_rdata, exp_q.pop_front());
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_FRAMING_EN, 32'h0);
      rd(OFS_SRC_RAW, 32'h0);
      rd(8'h24, 32'h0);
      vbus_drive_level <= 1'b1;
      rd(OFS_STATUS, 32'h1);
      vbus_drive_level <= 1'b0;
      rd(OFS_STATUS, 32'h0);
      // One endpoint enable at a time, reserved bits set as well
      for (int i = 0; i < 8; i++) begin
         b = (i < 4) ? (32'h1 << i) : (32'h1 << (i + 12));
         wr(OFS_FRAMING_EN, b | 32'hfff0_fff0);
         settle();
         chk({24'h0, rx_act, tx_act}, 32'h1 << i);
         rd(OFS_FRAMING_EN, b);
      end
      wr(OFS_CONTROL, 32'hffff_ffff);
      settle();
      chk({24'h0, rx_act, tx_act}, 32'hff);
      rd(OFS_CONTROL, 32'h10);
      wr(OFS_CONTROL, 32'h0);
      // Every legal code in every field; code 2 is never programmed
      for (int k = 0; k < 4; k++) begin
         w = 32'h0;
         for (int j = 0; j < 4; j++) begin
            cd = 2'((k + j) % 3);
            w[2*j +: 2] = (cd == 2'd2) ? 2'd3 : cd;
         end
         wr(OFS_RX_AUTO_REQUEST_MODES, ($random(seed) & ~RX_AUTO_REQUEST_MODES_MASK) | w);
         settle();
         chk({24'h0, ar_modes}, w);
         rd(OFS_RX_AUTO_REQUEST_MODES, w);
      end
      // Software set and clear, with the interrupt unmasked
      wr(OFS_SRC_MASK, SRC_MASK);
      for (int k = 0; k < 4; k++) begin
         w = $random(seed);
         c = $random(seed);
         wr(OFS_SRC_SET, w);
         rd(OFS_SRC_RAW, w & SRC_MASK);
         wr(OFS_SRC_SET, 32'h0);
         wr(OFS_SRC_CLR, c);
         rd(OFS_SRC_RAW, w & SRC_MASK & ~c);
         rd(OFS_SRC_MASKED, w & SRC_MASK & ~c);
         settle();
         chk({31'h0, irq}, {31'h0, |(w & SRC_MASK & ~c)});
         wr(OFS_SRC_CLR, 32'hffff_ffff);
      end
      wr(OFS_SRC_RAW, 32'hffff_ffff);
      rd(OFS_SRC_RAW, 32'h0);
      // Core events, then an event racing a clear
      w = $random(seed);
      core_events <= w;
      @(posedge clk_sys);
      core_events <= 32'h0;
      rd(OFS_SRC_RAW, w & SRC_MASK);
      wr(OFS_SRC_CLR, 32'hffff_ffff);
      core_events <= 32'h0000_1001;
      wr(OFS_SRC_CLR, 32'hffff_ffff);
      core_events <= 32'h0;
      rd(OFS_SRC_RAW, 32'h0000_1001);
      wr(OFS_SRC_MASK, 32'h0);
      settle();
      chk({31'h0, irq}, 32'h0);
      rd(OFS_SRC_MASKED, 32'h0);
      repeat (3) @(posedge clk_sys);
      report_and_stop();
   end
endmodule : tb
